// file: hw/bts_sbto_cmd.sv
// Purpose: Parses the trim program command and sends the ASCII reply.
// Assumes: Receiver and transmitter bytes share MCLK_IN; no syncing.
// Notes: Checksum covers the lead-in through the comma before it.
`timescale 1ns/100ps
`default_nettype none
module bts_sbto_cmd #(
    parameter int TRIM_W = 32
) (
    // Clock and reset.
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    // Command byte stream.
    input wire logic [7:0] RX_DATA_IN,
    input wire logic RX_VALID_IN,
    output logic RX_READY_OUT,
    // Reply byte stream.
    output logic [7:0] TX_DATA_OUT,
    output logic TX_VALID_OUT,
    input wire logic TX_READY_IN,
    // Nine trim offsets, gyro XYZ, accel XYZ, incl XYZ from bit 0 up.
    output logic [9*TRIM_W-1:0] TRIM_OUT
);
    localparam int W = TRIM_W;
    // Refuse widths that the twelve-digit converter cannot print.
    if (TRIM_W < 16 || TRIM_W > 36) begin : g_bad_width
        $error("TRIM_W must lie between 16 and 36");
    end

    // Checksum of one byte folded into a running value.
    function automatic logic [7:0] crc8(input logic [7:0] c,
                                        input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int k = 0; k < 8; k++) begin
            r = r[7] ? ((r << 1) ^ bts_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    bts_pkg::bts_state_t st_q, st_d;
    logic rdy_q, rdy_d, act_q, act_d, name_bad_q, name_bad_d, bad_q, bad_d;
    logic [2:0] fld_q, fld_d, pos_q, pos_d, nf_q, nf_d;
    logic neg_q, neg_d, in_frac_q, in_frac_d, in_exp_q, in_exp_d;
    logic eneg_q, eneg_d, num_bad_q, num_bad_d;
    logic [47:0] mant_q, mant_d;
    logic [3:0] frac_q, frac_d;
    logic [4:0] exp_q, exp_d;
    logic [15:0] num_q, num_d;
    logic [7:0] ch2_q, ch2_d, ch3_q, ch3_d, crc_q, crc_d;
    logic [7:0] snap_q, snap_d, tx_data_q, tx_data_d;
    logic signed [7:0] scale_q, scale_d;
    logic [9*W-1:0] trim_q, trim_d;
    logic [3:0] status_q, status_d, item_q, item_d, nd_q, nd_d, di_q, di_d;
    logic [2:0] hpos_q, hpos_d, dec_q, dec_d;
    logic [W-1:0] work_q, work_d;
    logic [3:0] dig_q [12];
    logic [3:0] dig_d [12];
    logic sgn_q, sgn_d, dot_q, dot_d, tail_q, tail_d, tx_valid_q, tx_valid_d;
    logic take, is_dig, tx_free, send, cl_ok, ax_ok;
    logic [3:0] digit;
    logic [7:0] b, tx_byte;
    logic [W-1:0] val, mag;
    logic [3:0] cl_base;
    logic [1:0] ax;
    logic [8:0] sel;

    // Next-state logic for parsing, applying and replying.
    always_comb begin
        st_d = st_q; rdy_d = rdy_q; act_d = act_q;
        name_bad_d = name_bad_q; bad_d = bad_q; fld_d = fld_q;
        pos_d = pos_q; nf_d = nf_q; neg_d = neg_q; in_frac_d = in_frac_q;
        in_exp_d = in_exp_q; eneg_d = eneg_q; num_bad_d = num_bad_q;
        mant_d = mant_q; frac_d = frac_q; exp_d = exp_q; num_d = num_q;
        ch2_d = ch2_q; ch3_d = ch3_q; crc_d = crc_q; snap_d = snap_q;
        scale_d = scale_q; trim_d = trim_q; status_d = status_q;
        item_d = item_q; nd_d = nd_q; di_d = di_q; hpos_d = hpos_q;
        dec_d = dec_q; work_d = work_q; dig_d = dig_q; sgn_d = sgn_q;
        dot_d = dot_q; tail_d = tail_q; tx_data_d = tx_data_q;
        b = RX_DATA_IN;
        take = RX_VALID_IN && rdy_q;
        digit = 4'(b - bts_pkg::CH_ZERO);
        is_dig = (b >= bts_pkg::CH_ZERO) && (b <= bts_pkg::CH_NINE);
        tx_free = !tx_valid_q || TX_READY_IN;
        tx_valid_d = tx_valid_q && !TX_READY_IN;
        send = 1'b0; tx_byte = 8'h00;
        val = neg_q ? W'(-mant_q[W-1:0]) : mant_q[W-1:0];
        mag = '0; sel = '0; cl_ok = 1'b1; ax_ok = 1'b1;
        cl_base = 4'h0; ax = 2'h0;
        // Cluster and axis letters map to offset slots.
        case (ch2_q)
            bts_pkg::CH_GYRO: cl_base = 4'h0;
            bts_pkg::CH_ACC: cl_base = 4'h3;
            bts_pkg::CH_INC: cl_base = 4'h6;
            default: cl_ok = 1'b0;
        endcase
        case (ch3_q)
            bts_pkg::CH_AX_X: ax = 2'h0;
            bts_pkg::CH_AX_Y: ax = 2'h1;
            bts_pkg::CH_AX_Z: ax = 2'h2;
            default: ax_ok = 1'b0;
        endcase
        case (st_q)
            bts_pkg::S_RX: begin
                if (take) begin
                    crc_d = crc8(crc_q, b);
                    if (b == bts_pkg::CH_DOLLAR) begin
                        act_d = 1'b1; fld_d = 3'h0; pos_d = 3'h1;
                        name_bad_d = 1'b0; bad_d = 1'b0; neg_d = 1'b0;
                        mant_d = '0; frac_d = '0; in_frac_d = 1'b0;
                        in_exp_d = 1'b0; eneg_d = 1'b0; exp_d = '0;
                        num_d = '0; num_bad_d = 1'b0;
                        // Empty selector fields must not reuse old letters.
                        ch2_d = 8'h00; ch3_d = 8'h00;
                        crc_d = crc8(bts_pkg::CRC_INIT, b);
                    end else if (act_q && b == bts_pkg::CH_CR) begin
                        act_d = 1'b0;
                        // Bad checksum or foreign command: no reply.
                        if (!name_bad_q && fld_q >= 3'h2 && !num_bad_q &&
                            num_q == {8'h00, snap_q}) begin
                            nf_d = fld_q;
                            scale_d = 8'(bts_pkg::FRAC_BASE - int'(frac_q) +
                                (eneg_q ? -int'(exp_q) : int'(exp_q)));
                            st_d = bts_pkg::S_SCALE;
                        end
                    end else if (act_q && b == bts_pkg::CH_COMMA) begin
                        snap_d = crc8(crc_q, b);
                        if (fld_q == 3'h0 && pos_q != bts_pkg::CMD_LEN)
                            name_bad_d = 1'b1;
                        if (fld_q == 3'h1 && pos_q == 3'h0) bad_d = 1'b1;
                        if (fld_q != 3'h7) fld_d = fld_q + 3'h1;
                        pos_d = 3'h0; num_d = '0; num_bad_d = 1'b0;
                    end else if (act_q) begin
                        if (pos_q != 3'h7) pos_d = pos_q + 3'h1;
                        if (!is_dig) num_bad_d = 1'b1;
                        else if (num_q < 16'h03E8)
                            num_d = 16'(num_q * 16'd10 + 16'(digit));
                        case (fld_q)
                            3'h0: begin
                                if (pos_q >= bts_pkg::CMD_LEN ||
                                    b != bts_pkg::CMD_TXT[39-8*pos_q -: 8])
                                    name_bad_d = 1'b1;
                            end
                            3'h1: begin
                                if (is_dig && in_exp_q) begin
                                    exp_d = 5'(exp_q * 5'd10 + 5'(digit));
                                end else if (is_dig) begin
                                    mant_d = 48'(mant_q * 48'd10 + 48'(digit));
                                    if (in_frac_q) frac_d = frac_q + 4'h1;
                                end else if (b == bts_pkg::CH_MINUS) begin
                                    if (in_exp_q) eneg_d = 1'b1;
                                    else if (pos_q == 3'h0) neg_d = 1'b1;
                                    else bad_d = 1'b1;
                                end else if (b == bts_pkg::CH_DOT) begin
                                    if (in_frac_q || in_exp_q) bad_d = 1'b1;
                                    in_frac_d = 1'b1;
                                end else if (b == bts_pkg::CH_EXP_LC ||
                                             b == bts_pkg::CH_EXP_UC) begin
                                    in_exp_d = 1'b1;
                                end else if (b != bts_pkg::CH_PLUS) begin
                                    bad_d = 1'b1;
                                end
                            end
                            3'h2: begin
                                ch2_d = b;
                                if (pos_q != 3'h0) ch2_d = 8'h00;
                            end
                            3'h3: begin
                                ch3_d = b;
                                if (pos_q != 3'h0) ch3_d = 8'h00;
                            end
                            default: ;
                        endcase
                    end
                end
            end
            bts_pkg::S_SCALE: begin
                // Bring the mantissa to 1e-7 units one decade a cycle.
                if (scale_q > 8'sh00) begin
                    mant_d = 48'(mant_q * 48'd10);
                    scale_d = scale_q - 8'sh01;
                end else if (scale_q < 8'sh00) begin
                    mant_d = mant_q / 48'd10;
                    scale_d = scale_q + 8'sh01;
                end else begin
                    st_d = bts_pkg::S_APPLY;
                end
            end
            bts_pkg::S_APPLY: begin
                status_d = bts_pkg::STATUS_OK;
                case (nf_q)
                    3'h2: sel = 9'h1FF;
                    3'h3: if (cl_ok) sel = 9'(9'h007 << cl_base);
                    3'h4: if (cl_ok && ax_ok)
                        sel = 9'(9'h001 << (cl_base + 4'(ax)));
                    default: ;
                endcase
                if (bad_q || sel == 9'h000) begin
                    sel = 9'h000;
                    status_d = bts_pkg::STATUS_BAD_ARG;
                end
                for (int k = 0; k < bts_pkg::NUM_AXES; k++) begin
                    if (sel[k]) trim_d[k*W +: W] = val;
                end
                hpos_d = 3'h0;
                crc_d = bts_pkg::CRC_INIT;
                st_d = bts_pkg::S_HDR;
            end
            bts_pkg::S_HDR: begin
                // Echoed name, comma, status digit, comma.
                if (tx_free) begin
                    send = 1'b1;
                    if (hpos_q == 3'h6)
                        tx_byte = bts_pkg::CH_ZERO + {4'h0, status_q};
                    else if (hpos_q == 3'h7)
                        tx_byte = bts_pkg::CH_COMMA;
                    else
                        tx_byte = bts_pkg::HDR_TXT[47-8*hpos_q -: 8];
                    hpos_d = hpos_q + 3'h1;
                    if (hpos_q == 3'h7) begin
                        item_d = 4'h0;
                        st_d = bts_pkg::S_LOAD;
                    end
                end
            end
            bts_pkg::S_LOAD: begin
                // Scale the offset to its printed precision.
                if (item_q == bts_pkg::CRC_ITEM) begin
                    mag = W'(crc_q);
                    dec_d = 3'h0;
                    sgn_d = 1'b0;
                end else begin
                    val = trim_q[item_q*W +: W];
                    mag = val[W-1] ? W'(-val) : val;
                    if (item_q < 4'h3) begin
                        mag = mag / W'(bts_pkg::DIV_GYRO);
                        dec_d = bts_pkg::DEC_GYRO;
                    end else if (item_q < 4'h6) begin
                        mag = mag / W'(bts_pkg::DIV_ACC);
                        dec_d = bts_pkg::DEC_ACC;
                    end else begin
                        dec_d = bts_pkg::DEC_INC;
                    end
                    sgn_d = val[W-1] && mag != '0;
                end
                work_d = mag;
                nd_d = 4'h0;
                st_d = bts_pkg::S_CONV;
            end
            bts_pkg::S_CONV: begin
                // Split into decimal digits, at least decimals plus one.
                dig_d[nd_q] = 4'(work_q % W'(10));
                work_d = work_q / W'(10);
                nd_d = nd_q + 4'h1;
                if (work_d == '0 && nd_q >= {1'b0, dec_q}) begin
                    di_d = nd_q;
                    dot_d = dec_q != 3'h0;
                    tail_d = 1'b0;
                    st_d = bts_pkg::S_EMIT;
                end
            end
            bts_pkg::S_EMIT: begin
                if (tx_free) begin
                    send = 1'b1;
                    if (sgn_q) begin
                        tx_byte = bts_pkg::CH_MINUS;
                        sgn_d = 1'b0;
                    end else if (dot_q && di_q == {1'b0, dec_q} - 4'h1) begin
                        tx_byte = bts_pkg::CH_DOT;
                        dot_d = 1'b0;
                    end else if (tail_q) begin
                        if (item_q == bts_pkg::CRC_ITEM) begin
                            tx_byte = bts_pkg::CH_CR;
                            st_d = bts_pkg::S_RX;
                        end else begin
                            tx_byte = bts_pkg::CH_COMMA;
                            item_d = item_q + 4'h1;
                            st_d = bts_pkg::S_LOAD;
                        end
                    end else begin
                        tx_byte = bts_pkg::CH_ZERO + {4'h0, dig_q[di_q]};
                        if (di_q == 4'h0) tail_d = 1'b1;
                        else di_d = di_q - 4'h1;
                    end
                end
            end
            default: st_d = bts_pkg::S_RX;
        endcase
        // Checksum covers every reply byte before the checksum field.
        if (send) begin
            tx_data_d = tx_byte;
            tx_valid_d = 1'b1;
            if (item_q != bts_pkg::CRC_ITEM || st_q == bts_pkg::S_HDR)
                crc_d = crc8(crc_q, tx_byte);
        end
        rdy_d = st_d == bts_pkg::S_RX;
    end

    // State registers.
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            st_q <= bts_pkg::S_RX; rdy_q <= 1'b0; act_q <= 1'b0;
            name_bad_q <= 1'b0; bad_q <= 1'b0; fld_q <= '0; pos_q <= '0;
            nf_q <= '0; neg_q <= 1'b0; in_frac_q <= 1'b0; in_exp_q <= 1'b0;
            eneg_q <= 1'b0; num_bad_q <= 1'b0; mant_q <= '0; frac_q <= '0;
            exp_q <= '0; num_q <= '0; ch2_q <= '0; ch3_q <= '0;
            crc_q <= bts_pkg::CRC_INIT; snap_q <= '0; scale_q <= '0;
            trim_q <= '0; status_q <= bts_pkg::STATUS_OK; item_q <= '0;
            nd_q <= '0; di_q <= '0; hpos_q <= '0; dec_q <= '0;
            work_q <= '0; dig_q <= '{default: 4'h0}; sgn_q <= 1'b0;
            dot_q <= 1'b0; tail_q <= 1'b0; tx_data_q <= '0;
            tx_valid_q <= 1'b0;
        end else begin
            st_q <= st_d; rdy_q <= rdy_d; act_q <= act_d;
            name_bad_q <= name_bad_d; bad_q <= bad_d; fld_q <= fld_d;
            pos_q <= pos_d; nf_q <= nf_d; neg_q <= neg_d;
            in_frac_q <= in_frac_d; in_exp_q <= in_exp_d; eneg_q <= eneg_d;
            num_bad_q <= num_bad_d; mant_q <= mant_d; frac_q <= frac_d;
            exp_q <= exp_d; num_q <= num_d; ch2_q <= ch2_d; ch3_q <= ch3_d;
            crc_q <= crc_d; snap_q <= snap_d; scale_q <= scale_d;
            trim_q <= trim_d; status_q <= status_d; item_q <= item_d;
            nd_q <= nd_d; di_q <= di_d; hpos_q <= hpos_d; dec_q <= dec_d;
            work_q <= work_d; dig_q <= dig_d; sgn_q <= sgn_d; dot_q <= dot_d;
            tail_q <= tail_d; tx_data_q <= tx_data_d;
            tx_valid_q <= tx_valid_d;
        end
    end

    // Outputs straight from the registers.
    assign RX_READY_OUT = rdy_q;
    assign TX_DATA_OUT = tx_data_q;
    assign TX_VALID_OUT = tx_valid_q;
    assign TRIM_OUT = trim_q;

    // Checks on the interpreter.
    a_all_axes_set: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        (st_q == bts_pkg::S_APPLY && !bad_q && nf_q == 3'h2)
        |=> trim_q == {9{$past(val)}} && status_q == bts_pkg::STATUS_OK)
        else $error("value alone did not set all offsets");
    a_cluster_only_set: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        (st_q == bts_pkg::S_APPLY && nf_q == 3'h3 && ch2_q == bts_pkg::CH_ACC)
        |=> $stable(trim_q[3*W-1:0]) && $stable(trim_q[9*W-1:6*W]))
        else $error("accel cluster write touched other clusters");
    a_one_axis_set: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        (st_q == bts_pkg::S_APPLY && nf_q == 3'h4 &&
         ch2_q == bts_pkg::CH_GYRO && ch3_q == bts_pkg::CH_AX_Y)
        |=> $stable(trim_q[W-1:0]) && $stable(trim_q[9*W-1:2*W]))
        else $error("single axis write touched another axis");
    a_reply_name_first: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        st_q == bts_pkg::S_APPLY
        |-> ##[1:2] (tx_valid_q && tx_data_q == bts_pkg::CH_HASH))
        else $error("reply did not open with the echoed name");
    a_item_in_order: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        $changed(item_q)
        |-> item_q == $past(item_q) + 4'h1 || item_q == 4'h0)
        else $error("offsets sent out of order");
    a_gyro_decimals: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        (st_q == bts_pkg::S_LOAD && item_q < 4'h3) |=> dec_q == 3'h5)
        else $error("gyro offset not printed with five decimals");
    a_acc_decimals: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        (st_q == bts_pkg::S_LOAD && item_q >= 4'h3 && item_q < 4'h6)
        |=> dec_q == 3'h6)
        else $error("accel offset not printed with six decimals");
    a_inc_decimals: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        (st_q == bts_pkg::S_LOAD && item_q >= 4'h6 && item_q < 4'h9)
        |=> dec_q == 3'h7)
        else $error("incl offset not printed with seven decimals");
    a_bad_sum_dropped: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        (take && act_q && b == bts_pkg::CH_CR && num_q != {8'h00, snap_q})
        |=> st_q == bts_pkg::S_RX && $stable(trim_q))
        else $error("message with bad checksum was acted on");
    a_tx_held: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        (tx_valid_q && !TX_READY_IN) |=> tx_valid_q && $stable(tx_data_q))
        else $error("reply byte dropped while stalled");
endmodule
`default_nettype wire

// file: hw/bts_pkg.sv
// Purpose: Constants for the trim-offset program command interpreter.
// Assumes: Byte stream arrives from a receiver on the same clock.
// Notes: Offsets are held internally as signed counts of 1e-7 units.
// Notes on behaviour
// - Value alone sets every axis offset.
// - Value plus cluster sets that cluster only.
// - Value, cluster, axis sets one axis; exponent allowed.
// - Reply echoes command name, then status zero, or one for a bad argument.
// - Reply lists nine offsets: gyro, accel, incl.
// - Gyro offsets printed with five decimals.
// - Accelerometer offsets printed with six decimals.
// - Inclinometer offsets printed with seven decimals.
package bts_pkg;
    // Characters of the framing and number syntax.
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_PLUS = 8'h2B;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_EXP_LC = 8'h65;
    localparam logic [7:0] CH_EXP_UC = 8'h45;
    // Cluster and axis selector letters.
    localparam logic [7:0] CH_GYRO = 8'h67;
    localparam logic [7:0] CH_ACC = 8'h61;
    localparam logic [7:0] CH_INC = 8'h69;
    localparam logic [7:0] CH_AX_X = 8'h78;
    localparam logic [7:0] CH_AX_Y = 8'h79;
    localparam logic [7:0] CH_AX_Z = 8'h7A;
    // Command text with its lead-in, and the reply header with comma.
    localparam logic [39:0] CMD_TXT = 40'h2473_6274_6F;
    localparam logic [2:0] CMD_LEN = 3'h5;
    localparam logic [47:0] HDR_TXT = 48'h2373_6274_6F2C;
    // Internal fraction digits and printed decimals per cluster.
    localparam int FRAC_BASE = 7;
    localparam logic [2:0] DEC_GYRO = 3'h5;
    localparam logic [2:0] DEC_ACC = 3'h6;
    localparam logic [2:0] DEC_INC = 3'h7;
    localparam int DIV_GYRO = 100;
    localparam int DIV_ACC = 10;
    localparam int NUM_AXES = 9;
    localparam logic [3:0] CRC_ITEM = 4'h9;
    // Execution status codes.
    localparam logic [3:0] STATUS_OK = 4'h0;
    localparam logic [3:0] STATUS_BAD_ARG = 4'h1;
    // Checksum generator.
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // Interpreter states.
    typedef enum logic [6:0] {
        S_RX = 7'h01, S_SCALE = 7'h02, S_APPLY = 7'h04, S_HDR = 7'h08,
        S_LOAD = 7'h10, S_CONV = 7'h20, S_EMIT = 7'h40
    } bts_state_t;
endpackage

// file: tb/bts_host_model.sv
// Purpose: Host on the far side of the command link.
// Assumes: Bytes change after a falling edge, replies are collected.
// Notes: The reply sink stalls at random to slow the device down.
`timescale 1ns/100ps
`default_nettype none
module bts_host_model (
    input wire logic clk_in,
    input wire logic rx_ready_in,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out
);
    string got[$];
    string cur = "";
    initial rx_valid_out = 1'b0;
    initial rx_data_out = 8'h00;
    initial tx_ready_out = 1'b0;
    // Sends each byte and holds it until the device takes it.
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            @(negedge clk_in);
            rx_data_out = s[i];
            rx_valid_out = 1'b1;
            do @(posedge clk_in); while (rx_ready_in !== 1'b1);
        end
        @(negedge clk_in);
        rx_valid_out = 1'b0;
        rx_data_out = ~rx_data_out;
    endtask
    // Randomly stalls the reply stream.
    always @(negedge clk_in) tx_ready_out <= ($urandom % 4) != 0;
    // Collects reply bytes up to the closing carriage return.
    always @(posedge clk_in) begin
        if (tx_valid_in && tx_ready_out) begin
            cur = {cur, string'(tx_data_in)};
            if (tx_data_in == 8'h0D) begin
                got.push_back(cur);
                cur = "";
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/bts_sbto_cmd_tb_top.sv
// Purpose: Self-checking bench of the trim program command.
// Assumes: Offsets are signed counts of 1e-7 units.
// Notes: Replies are predicted as whole strings, checksum included.
`timescale 1ns/100ps
`default_nettype none
module bts_sbto_cmd_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] rxd, txd;
    logic rxv, rxr, txv, txr;
    logic [287:0] trim;
    logic signed [31:0] t[9];
    string exp_q[$];
    int errors = 0;
    int samples_checked = 0;
    bts_sbto_cmd dut (.MCLK_IN(clk), .RST_IN(rst), .RX_DATA_IN(rxd),
        .RX_VALID_IN(rxv), .RX_READY_OUT(rxr), .TX_DATA_OUT(txd),
        .TX_VALID_OUT(txv), .TX_READY_IN(txr), .TRIM_OUT(trim));
    bts_host_model host (.clk_in(clk), .rx_ready_in(rxr),
        .rx_data_out(rxd), .rx_valid_out(rxv), .tx_data_in(txd),
        .tx_valid_in(txv), .tx_ready_out(txr));
    // Free-running clock, 100 ns period.
    always #50 clk = ~clk;
    // Checksum of a text with the reply's polynomial.
    function automatic logic [7:0] crc8(input string s);
        logic [7:0] c = 8'h00;
        for (int i = 0; i < s.len(); i++) begin
            c = c ^ s[i];
            repeat (8) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
        end
        return c;
    endfunction
    // Prints one offset slot with its cluster's decimals.
    function automatic string fmt(input int v, input int k);
        int dv = k < 3 ? bts_pkg::DIV_GYRO : k < 6 ? bts_pkg::DIV_ACC : 1;
        int d = k < 3 ? 5 : k < 6 ? 6 : 7;
        int m = (v < 0 ? -v : v) / dv;
        string f = $sformatf("%0d", m % (10 ** d));
        while (f.len() < d) f = {"0", f};
        f = $sformatf("%0d.%s", m / (10 ** d), f);
        if (m != 0 && v < 0) f = {"-", f};
        return f;
    endfunction
    // Sends one command, predicts its reply and checks the offsets.
    // The kind bad is 1 for a wrong checksum, 2 for an unknown cluster.
    task automatic cmd(string a, int lo, int hi, int v, int bad);
        string s = {"$sbto,", a, ","};
        string r = bad == 2 ? "#sbto,1," : "#sbto,0,";
        logic [7:0] c = crc8(s) ^ 8'(bad == 1);
        s = {s, $sformatf("%0d\r", c)};
        if (bad != 1) begin
            if (bad == 0) for (int k = lo; k <= hi; k++) t[k] = v;
            for (int k = 0; k < 9; k++) r = {r, fmt(t[k], k), ","};
            exp_q.push_back({r, $sformatf("%0d\r", crc8(r))});
        end
        host.send(s);
        repeat (400) @(posedge clk);
        for (int k = 0; k < 9; k++) begin
            samples_checked++;
            if (trim[k*32 +: 32] !== t[k]) begin
                errors++;
                $display("Error %0t slot %0d", $time, k);
            end
        end
        $display("done %s", a);
    endtask
    // Compares every finished reply with the oldest prediction.
    initial forever begin
        string r, e;
        wait (host.got.size() != 0);
        r = host.got.pop_front();
        e = exp_q.size() != 0 ? exp_q.pop_front() : "";
        samples_checked++;
        if (r != e) begin
            errors++;
            $display("Error %0t reply %s", $time, r);
        end
    end
    task automatic end_of_test();
        if (exp_q.size() != 0) begin
            errors++;
            $display("Error %0t %0d replies missing", $time, exp_q.size());
        end
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        end_of_test();
    end
    // Main sequence of commands.
    initial begin
        int v;
        string a, cl = "gai", axn = "xyz";
        void'($urandom(32'he25a3c1b));
        foreach (t[k]) t[k] = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        cmd("-1.5e-2", 0, 8, -150000, 0);
        cmd("2.5E-1,a", 3, 5, 2500000, 0);
        for (int k = 0; k < 9; k++) begin
            v = $urandom_range(9999999);
            v = $urandom % 2 ? -v : v;
            a = $sformatf("0.%07d,%c,%c", v < 0 ? -v : v, cl[k/3], axn[k%3]);
            if (v < 0) a = {"-", a};
            cmd(a, k, k, v, 0);
        end
        cmd("7", 0, 8, 70000000, 1);
        cmd("0.5,q", 0, 8, 0, 2);
        cmd("0", 0, 8, 0, 0);
        end_of_test();
    end
endmodule
`default_nettype wire
